// ---- design/wwd_pkg.sv ----
// package: register map, field layout, reset values and timing of the watchdog
package wwd_pkg;
    // register byte offsets on the bus
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_MODE = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    // command register fields
    localparam int CMD_RESTART_BIT = 0;
    localparam int CMD_KEY_LSB = 24;
    localparam logic [7:0] CMD_KEY = 8'hA5;
    // mode register fields
    localparam int MODE_RELOAD_LSB = 0;
    localparam int MODE_FIEN_BIT = 12;
    localparam int MODE_RSTEN_BIT = 13;
    localparam int MODE_PROC_BIT = 14;
    localparam int MODE_DIS_BIT = 15;
    localparam int MODE_WIN_LSB = 16;
    localparam int MODE_DBGHLT_BIT = 28;
    localparam int MODE_IDLEHLT_BIT = 29;
    localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
    localparam logic [31:0] MODE_MASK = 32'h3FFF_FFFF;
    // status register fields
    localparam int STAT_UNF_BIT = 0;
    localparam int STAT_ERR_BIT = 1;
    // counter geometry and prescaler
    localparam int CNT_W = 12;
    localparam int PRESCALE_DIV = 128;
    localparam int PRESCALE_W = 7;
endpackage

// ---- design/wwd_prescaler.sv ----
// divide-by-128 prescaler on the slow clock enable
`timescale 1ns/1ps
module wwd_prescaler #(
    parameter int DIV = wwd_pkg::PRESCALE_DIV,
    parameter int W = wwd_pkg::PRESCALE_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic restart,
    input wire logic slow_en,
    input wire logic run,
    // tick out
    output logic tick
);
    // state of the divider
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } wwd_div_t;
    wwd_div_t s_q, s_d;

    localparam logic [W-1:0] LAST = W'(DIV - 1);

    // count slow clock edges while running; restart starts from zero
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (restart) begin
            s_d.cnt = '0;
        end else if (slow_en && run) begin
            if (s_q.cnt == LAST) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + W'(1);
            end
        end
    end

    // register the divider state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    // a tick never follows a restart in the next cycle
    a_restart_clears: assert property (
        @(posedge clk) disable iff (sys_rst)
        restart |=> !tick)
        else $error("tick right after restart");
endmodule

// ---- design/wwd_top.sv ----
// windowed watchdog: counter, window check, flags, fault and wishbone slave
// Functional notes
// - twelve-bit down counter loaded from reload value
// - counter ticks at slow clock over 128
// - reset: reload 0xFFF, fault reset enabled
// - disable bit stops watchdog counting
// - mode write reloads and restarts counter
// - mode register writable once after reset
// - processor reset restarts with initial values
// - keyed restart reloads counter, resets prescaler
// - wrong key write has no effect
// - key byte must be 0xA5
// - underflow sets flag, fault if enabled
// - restart above window flags error, fault
// - window not below reload: no errors
// - flags interrupt only with interrupt enable
// - fault with reset enable requests watchdog reset
// - status read clears flags, interrupt, fault
// - reset is system-wide or processor only
// - processor select limits reset to processor
// - counter freezes in debug or idle
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
module wwd_top (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // timing and system state
    input wire logic slow_clk_en,
    input wire logic cpu_debug,
    input wire logic sys_idle,
    // fault outputs
    output logic wdt_irq,
    output logic wdt_fault,
    output logic fault_sys_reset,
    output logic fault_proc_reset,
    output logic [wwd_pkg::CNT_W-1:0] counter_value
);
    localparam int CW = wwd_pkg::CNT_W;

    // bus timing: a request is taken on the edge where cyc and stb are high
    // and no ack is pending; ack and read data follow one cycle later and
    // stand for one cycle only, so a master needs two cycles per access.
    // the counter counts down only on the prescaler tick, which is one cycle wide
    // and comes the cycle after a running slow clock pulse; all else happens on clk.
    // sys_rst is the processor reset: it re-arms the write-once mode
    // register and brings back the default running configuration, so a
    // watchdog that has fired comes back up armed and counting.

    // whole state of the block
    typedef struct packed {
        logic [31:0] mode;        // mode register image
        logic mode_locked;        // set by the first mode write
        logic [CW-1:0] cnt;       // down counter
        logic unf;                // underflow flag
        logic err;                // restart error flag
        logic ack;                // bus acknowledge
        logic [31:0] rdata;       // read data
    } wwd_state_t;
    wwd_state_t s_q, s_d;

    // field decode, used on the stored image and on written data
    // both fields are twelve bits wide, matching the counter
    function automatic logic [CW-1:0] reload_of(input logic [31:0] m);
        reload_of = m[wwd_pkg::MODE_RELOAD_LSB +: CW];
    endfunction
    function automatic logic [CW-1:0] window_of(input logic [31:0] m);
        window_of = m[wwd_pkg::MODE_WIN_LSB +: CW];
    endfunction

    // the slave answers every access, mapped or not, in one cycle
    // bus access decode
    logic acc, wr, rd, hit_cmd, hit_mode, hit_stat, full_word;
    assign acc = wb_cyc_i && wb_stb_i && !s_q.ack;
    assign wr = acc && wb_we_i;
    assign rd = acc && !wb_we_i;
    assign hit_cmd = wb_adr_i == wwd_pkg::OFS_CMD;
    assign hit_mode = wb_adr_i == wwd_pkg::OFS_MODE;
    assign hit_stat = wb_adr_i == wwd_pkg::OFS_STAT;
    // partial writes are ignored: key and fields live in several lanes
    assign full_word = wb_sel_i == 4'hF;

    // the key lives in the top byte; a wrong key aborts the whole write,
    // restart bit included, so stray writes cannot feed the watchdog
    // command and mode write events
    logic key_ok, restart_cmd, mode_wr, restart_any;
    assign key_ok = wb_dat_i[wwd_pkg::CMD_KEY_LSB +: 8] == wwd_pkg::CMD_KEY;
    assign restart_cmd = wr && hit_cmd && full_word && key_ok
        && wb_dat_i[wwd_pkg::CMD_RESTART_BIT];
    assign mode_wr = wr && hit_mode && full_word && !s_q.mode_locked;
    assign restart_any = restart_cmd || mode_wr;

    // the halt inputs are levels from the system; they freeze both the
    // counter and the prescaler, so no part of a period is lost
    // running condition: not disabled and not halted
    logic dis, run;
    assign dis = s_q.mode[wwd_pkg::MODE_DIS_BIT];
    assign run = !dis
        && !(cpu_debug && s_q.mode[wwd_pkg::MODE_DBGHLT_BIT])
        && !(sys_idle && s_q.mode[wwd_pkg::MODE_IDLEHLT_BIT]);

    // the prescaler restarts on both kinds of restart, so a fresh count
    // always lasts the full number of slow clock pulses
    // prescaler tick
    logic tick;
    wwd_prescaler #(
        .DIV(wwd_pkg::PRESCALE_DIV),
        .W(wwd_pkg::PRESCALE_W)
    ) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(restart_any),
        .slow_en(slow_clk_en),
        .run(run),
        .tick(tick)
    );

    // window check: error only if above window; a window at or above the
    // reload value can never be exceeded, so it needs no special case
    logic win_err, unf_ev, err_ev;
    assign win_err = s_q.cnt > window_of(s_q.mode);
    // restart error is checked even when the watchdog is disabled
    assign err_ev = restart_cmd && win_err;
    assign unf_ev = tick && run && s_q.cnt == '0 && !restart_any;

    // next state
    // all next values start from the current state and are overridden
    always_comb begin
        s_d = s_q;
        // ack is raised for one cycle per taken request
        s_d.ack = acc;
        // mode register write once
        // later writes are still acknowledged, only their data is dropped
        if (mode_wr) begin
            s_d.mode = wb_dat_i & wwd_pkg::MODE_MASK;
            s_d.mode_locked = 1'b1;
        end
        // counter: reload on restart, decrement on tick
        // a mode write carries its own reload value, so it comes first;
        // a restart that fails the window check does not reload; a tick in that cycle still counts down
        if (mode_wr) begin
            s_d.cnt = reload_of(wb_dat_i);
        end else if (restart_cmd && !win_err) begin
            s_d.cnt = reload_of(s_q.mode);
        end else if (tick && run) begin
            if (s_q.cnt == '0) begin
                s_d.cnt = reload_of(s_q.mode);
            end else begin
                s_d.cnt = s_q.cnt - CW'(1);
            end
        end
        // status read clears, but a new event in the same cycle wins
        if (rd && hit_stat) begin
            s_d.unf = 1'b0;
            s_d.err = 1'b0;
        end
        if (unf_ev) begin
            s_d.unf = 1'b1;
        end
        if (err_ev) begin
            s_d.err = 1'b1;
        end
        // read data mux, unmapped addresses read as zero
        // the mode image is returned whole, reserved bits read as zero
        s_d.rdata = '0;
        if (rd) begin
            if (hit_mode) begin
                s_d.rdata = s_q.mode;
            end else if (hit_stat) begin
                s_d.rdata[wwd_pkg::STAT_UNF_BIT] = s_q.unf;
                s_d.rdata[wwd_pkg::STAT_ERR_BIT] = s_q.err;
            end
        end
    end

    // register state; reset restores initial values and restarts
    // fields are set by name so the defaults stay easy to follow
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q.mode <= wwd_pkg::MODE_RESET;
            s_q.mode_locked <= 1'b0;
            s_q.cnt <= reload_of(wwd_pkg::MODE_RESET);
            s_q.unf <= 1'b0;
            s_q.err <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs
    // the resets out are levels; the reset controller decides how long
    // to hold them and feeds its processor reset back as sys_rst
    logic any_flag, rst_en;
    assign any_flag = s_q.unf || s_q.err;
    assign rst_en = s_q.mode[wwd_pkg::MODE_RSTEN_BIT];
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign counter_value = s_q.cnt;
    assign wdt_irq = any_flag && s_q.mode[wwd_pkg::MODE_FIEN_BIT];
    // the fault line follows the flags so a status read drops it
    assign wdt_fault = any_flag && rst_en;
    assign fault_proc_reset = wdt_fault;
    assign fault_sys_reset = wdt_fault
        && !s_q.mode[wwd_pkg::MODE_PROC_BIT];

    // assertions: bus handshake first, then the counter and flag rules;
    // each one guards the logic written above it in this file
    // ack is a single-cycle pulse, so a master can never see it twice
    a_ack_one_cycle: assert property (
        @(posedge clk) disable iff (sys_rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    // every taken request is answered exactly one cycle later
    a_ack_follows: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("no ack after request");

    // read data is zero except in the acknowledge cycle
    a_read_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        !wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");

    // once locked the mode image never changes until reset
    a_mode_once: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_q.mode_locked |=> $stable(s_q.mode))
        else $error("locked mode register changed");

    // an accepted mode write loads the counter from the written value
    a_mode_reload: assert property (
        @(posedge clk) disable iff (sys_rst)
        mode_wr |=> s_q.cnt == reload_of($past(wb_dat_i)))
        else $error("mode write did not reload");

    // a command without the key leaves counter and error flag alone;
    // a tick in the same cycle would move the counter, so it is excluded
    a_bad_key: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wr && hit_cmd && !key_ok && !tick)
        |=> $stable(s_q.cnt) && $stable(s_q.err))
        else $error("unkeyed command had effect");

    // a keyed restart inside the window reloads from the stored image
    a_restart_reload: assert property (
        @(posedge clk) disable iff (sys_rst)
        (restart_cmd && !win_err && !mode_wr)
        |=> s_q.cnt == reload_of($past(s_q.mode)))
        else $error("restart did not reload");

    // a restart above the window always ends in the error flag
    a_win_error: assert property (
        @(posedge clk) disable iff (sys_rst)
        (restart_cmd && s_q.cnt > window_of(s_q.mode)) |=> s_q.err)
        else $error("window error not flagged");

    // the window check still works with the watchdog disabled
    a_err_disabled: assert property (
        @(posedge clk) disable iff (sys_rst)
        (err_ev && dis) |=> s_q.err && wdt_fault == $past(rst_en))
        else $error("disabled watchdog missed a window error");

    // a running tick above zero takes exactly one off the counter
    a_tick_dec: assert property (
        @(posedge clk) disable iff (sys_rst)
        (tick && run && !restart_any && s_q.cnt != '0)
        |=> s_q.cnt == $past(s_q.cnt) - CW'(1))
        else $error("tick did not decrement");

    // a tick at zero reloads and leaves the underflow flag set
    a_unf_reload: assert property (
        @(posedge clk) disable iff (sys_rst)
        unf_ev |=> s_q.cnt == reload_of($past(s_q.mode)) && s_q.unf)
        else $error("underflow did not reload");

    // an underflow with reset enabled raises the fault line
    a_unf_fault: assert property (
        @(posedge clk) disable iff (sys_rst)
        (unf_ev && rst_en) |=> wdt_fault && s_q.unf)
        else $error("underflow fault missing");

    // the fault line stays up until status is read, the mode is written or reset comes
    a_fault_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wdt_fault && !(rd && hit_stat) && !mode_wr) |=> wdt_fault)
        else $error("fault dropped without a status read");

    // a status read with no new event clears fault and interrupt
    a_read_clear: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd && hit_stat && !unf_ev && !err_ev) |=> !wdt_fault && !wdt_irq)
        else $error("status read did not clear");

    // the interrupt needs the enable bit and a pending flag
    a_irq_gate: assert property (
        @(posedge clk) disable iff (sys_rst)
        wdt_irq |-> s_q.mode[wwd_pkg::MODE_FIEN_BIT] && any_flag)
        else $error("interrupt without enable");

    // halted or disabled, the counter only moves on a restart
    a_halt_freeze: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!run && !restart_any) |=> $stable(s_q.cnt))
        else $error("counter moved while halted");

    // a system reset request always carries the processor reset too
    a_sys_has_proc: assert property (
        @(posedge clk) disable iff (sys_rst)
        fault_sys_reset |-> fault_proc_reset)
        else $error("system reset without processor reset");

    // processor-only select keeps the system reset quiet
    a_proc_only: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wdt_fault && s_q.mode[wwd_pkg::MODE_PROC_BIT])
        |-> fault_proc_reset && !fault_sys_reset)
        else $error("processor-only select ignored");

    // with the select clear a fault asks for every reset
    a_all_resets: assert property (
        @(posedge clk) disable iff (sys_rst)
        (wdt_fault && !s_q.mode[wwd_pkg::MODE_PROC_BIT])
        |-> fault_sys_reset && fault_proc_reset)
        else $error("full reset not requested");
endmodule

// ---- verif/windowed_watchdog_timer_test.sv ----
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
    // clock, resets and bus master
    logic clk = 1'b0;
    logic tb_rst = 1'b1;
    logic pm_rst;
    logic sys_rst;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    // system state and outputs
    logic cpu_debug = 1'b0;
    logic sys_idle = 1'b0;
    logic wdt_irq, wdt_fault, fault_sys_reset, fault_proc_reset;
    logic [wwd_pkg::CNT_W-1:0] counter_value;
    logic [31:0] rd; // data of the last bus cycle
    int failures = 0;
    int n_compared = 0;

    always #25 clk = ~clk;
    // the bench or the modelled reset controller resets the block
    assign sys_rst = tb_rst | pm_rst;

    // slow clock pulses every cycle so a tick takes 128 cycles
    wwd_top i_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .slow_clk_en(1'b1), .cpu_debug(cpu_debug),
        .sys_idle(sys_idle), .wdt_irq(wdt_irq), .wdt_fault(wdt_fault),
        .fault_sys_reset(fault_sys_reset),
        .fault_proc_reset(fault_proc_reset),
        .counter_value(counter_value));

    wwd_rstc_model i_rstc (.clk(clk), .fault_sys_reset(fault_sys_reset),
        .fault_proc_reset(fault_proc_reset), .proc_rst(pm_rst));

    // verdict and end of run
    task automatic report_and_stop();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one compare for every result, zero-extended to a word
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // classic wishbone cycle, entered just after a rising edge
    task automatic wb(input logic we, input logic [3:0] adr,
            input logic [31:0] wd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_wdat <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) begin
            failures++; // no answer
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask

    // bench reset, held for four cycles
    task automatic do_reset();
        tb_rst <= 1'b1;
        repeat (4) @(posedge clk);
        tb_rst <= 1'b0;
        @(posedge clk);
    endtask

    // waits for the modelled reset to come and go; it must really come
    task automatic wait_reset();
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (!(seen && pm_rst === 1'b0) && n < 60) begin
            @(posedge clk);
            n++;
            if (pm_rst === 1'b1) begin
                seen = 1'b1;
            end
        end
        check({31'h0, seen && pm_rst === 1'b0}, 32'h1);
        @(posedge clk);
    endtask

    // reset values and an unmapped read
    task automatic t_defaults();
        cpu_debug <= 1'b1;
        wb(1'b0, 4'h4, 32'h0);
        check(rd, 32'h3FFF_2FFF);
        wb(1'b0, 4'hC, 32'h0);
        check(rd, 32'h0);
        check({20'h0, counter_value}, 32'hFFF);
        // default mode halts in debug, so no tick may land
        repeat (300) @(posedge clk);
        check({20'h0, counter_value}, 32'hFFF);
        cpu_debug <= 1'b0;
    endtask

    // counting, refused commands, keyed restart and prescaler reset
    task automatic t_restart_key();
        do_reset();
        repeat (300) @(posedge clk);
        check({20'h0, counter_value}, 32'hFFD);
        wb(1'b1, 4'h0, 32'h5A00_0001);
        wb(1'b1, 4'h0, 32'hA500_0000);
        check({20'h0, counter_value}, 32'hFFD);
        wb(1'b1, 4'h0, 32'hA500_0001);
        repeat (120) @(posedge clk);
        check({20'h0, counter_value}, 32'hFFF);
        wb(1'b0, 4'h8, 32'h0);
        check(rd, 32'h0);
    endtask

    // write-once mode, idle halt, underflow and clear on read
    task automatic t_underflow();
        int n;
        do_reset();
        sys_idle <= 1'b1;
        wb(1'b1, 4'h4, 32'h2003_1003);
        check({20'h0, counter_value}, 32'h3);
        wb(1'b1, 4'h4, 32'h0000_2005);
        wb(1'b0, 4'h4, 32'h0);
        check(rd, 32'h2003_1003);
        repeat (300) @(posedge clk);
        check({20'h0, counter_value}, 32'h3);
        sys_idle <= 1'b0;
        n = 0;
        while (wdt_irq !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check({20'h0, counter_value}, 32'h3);
        check({31'h0, wdt_fault}, 32'h0);
        wb(1'b0, 4'h8, 32'h0);
        check(rd, 32'h1);
        check({31'h0, wdt_irq}, 32'h0);
    endtask

    // restart above the window with processor-only reset selected
    task automatic t_window_proc();
        do_reset();
        wb(1'b1, 4'h4, 32'h0002_6008);
        wb(1'b1, 4'h0, 32'hA500_0001);
        check({wdt_fault, wdt_irq, fault_sys_reset, fault_proc_reset},
            32'h9);
        wait_reset();
        wb(1'b0, 4'h4, 32'h0);
        check(rd, 32'h3FFF_2FFF);
        wb(1'b0, 4'h8, 32'h0);
        check(rd, 32'h0);
    endtask

    // disabled watchdog still flags a window error, system reset
    task automatic t_disabled_sys();
        wb(1'b1, 4'h4, 32'h0002_A008);
        repeat (300) @(posedge clk);
        check({20'h0, counter_value}, 32'h8);
        wb(1'b1, 4'h0, 32'hA500_0001);
        check({wdt_fault, wdt_irq, fault_sys_reset, fault_proc_reset},
            32'hB);
        wait_reset();
        check({31'h0, wdt_fault}, 32'h0);
    endtask

    // main sequence
    initial begin
        do_reset();
        t_defaults();
        t_restart_key();
        t_underflow();
        t_window_proc();
        t_disabled_sys();
        report_and_stop();
    end

    // watchdog: the run needs about 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule

// ---- verif/wwd_rstc_model.sv ----
// reset controller model: turns a watchdog fault into a processor reset
`timescale 1ns/1ps
module wwd_rstc_model #(
    parameter int DELAY = 8
) (
    // clock
    input wire logic clk,
    // fault requests from the watchdog
    input wire logic fault_sys_reset,
    input wire logic fault_proc_reset,
    // reset driven back into the watchdog
    output logic proc_rst
);
    int cnt = 0; // cycles since the fault was seen
    initial proc_rst = 1'b0;
    // both requests reset the processor here; the wider system reset is
    // not modelled, since only the watchdog sits behind this model
    always @(posedge clk) begin
        if (cnt == 0 && (fault_sys_reset || fault_proc_reset)) begin
            cnt <= 1;
        end else if (cnt > 0 && cnt < DELAY + 2) begin
            cnt <= cnt + 1;
        end else begin
            cnt <= 0;
        end
        // the delay leaves the bench time to look at the fault lines
        proc_rst <= (cnt >= DELAY);
    end
endmodule
